// ===== core/pkm_pkg.sv
//
// How it works
// - Form feed acts only offline with data and ready lit; otherwise ignored.
// - Alarm-clear returns to ready, turns alarm off, blanks the message.
// - Test key: once page A, twice font list, hold runs page B repeatedly.
// - Several test presses in a row stop the test and show test-stopped.
// - Reset clears page memory, reloads settings; held over 10 s enters control mode.
// - Menu key enters setup menu and remaps dual-labelled keys to navigation.
// - Duplex key toggles sides only with the output selector facedown.
// - Host has no path to change simplex or duplex; only the key.
// - Feeder key steps auto, lower, upper, manual, option with indicator and text.
// - Manual feed offered only in simplex test mode, skipped otherwise.
// - Option feed offered only with envelope feeder, faceup and simplex.
// - Down goes setup to feature to value; ignored at value level.
// - Up goes value to feature to setup, stopping at offline ready.
// - Left and right scroll entries, wrapping after the last available one; offset values stop at 0.0 and 10.
// - Selected entry shown left-justified with cursor, updated on each scroll.
// - Enter commits the selected value and marks it current with equals.
// - Feeder menu value has the same effect as the feeder key.
// - Auto feed picks a cassette and lights it; size mismatch raises error.
// - Manual feed prompts; paper sensed engages feed clutch to registration.
// - Offset steps by 0.5 per key press, each step 15 dots.
// - Offset limited from 0.0 (sheet centre) up to 10.
// - X offset moves beam start; Y offset moves registration clutch timing.
// - Keys disabled while online are ignored and sound the beeper.
package pkm_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned DEBOUNCE_MS   = 10;
	localparam int unsigned RESET_HOLD_S  = 10;
	localparam int unsigned TEST_HOLD_MS  = 1000;
	localparam int unsigned MULTI_WIN_MS  = 500;
	localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * (CLK_HZ / 1000);
	localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_S * CLK_HZ;
	localparam int unsigned TEST_HOLD_CYC = TEST_HOLD_MS * (CLK_HZ / 1000);
	localparam int unsigned MULTI_WIN_CYC = MULTI_WIN_MS * (CLK_HZ / 1000);

	// ************************************************************
	// Keys and settings
	// ************************************************************
	localparam int NUM_KEYS     = 7;
	localparam int KEY_FORMFEED = 0;
	localparam int KEY_ALARM    = 1;
	localparam int KEY_TEST     = 2;
	localparam int KEY_RESET    = 3;
	localparam int KEY_MENU     = 4;
	localparam int KEY_DUPLEX   = 5;
	localparam int KEY_FEEDER   = 6;
	localparam logic [4:0] OFFSET_MAX    = 5'h14; // 10.0 in half steps
	localparam logic [4:0] OFFSET_RST    = 5'h00;
	localparam logic [8:0] DOTS_PER_STEP = 9'h00f;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_OFFSET = 8'h08;
	localparam logic [1:0] CTRL_RST   = 2'h0;

	typedef enum logic [1:0] {LV_OFFLINE, LV_SETUP, LV_FEATURE, LV_VALUE} pkm_level_t;
	typedef enum logic [2:0] {FD_AUTO, FD_LOWER, FD_UPPER, FD_MANUAL, FD_OPTION} pkm_feed_t;
	typedef enum logic [2:0] {MS_READY, MS_BLANK, MS_TEST_STOP, MS_FEEDER,
		MS_LOAD_MANUAL, MS_SIZE_ERR} pkm_msg_t;
	typedef enum logic [1:0] {TS_IDLE, TS_COUNT, TS_RUN} pkm_test_t;

	// Next offered feed source, skipping choices the configuration hides
	function automatic pkm_feed_t pkmNextFeed(input pkm_feed_t cur, input logic fwd,
		input logic manOk, input logic optOk);
		logic [2:0] c;
		logic       found;
		c = cur;
		found = 1'b0;
		for (int i = 0; i < 5; i++) begin
			if (!found) begin
				c = fwd ? ((c == 3'h4) ? 3'h0 : c + 3'h1) : ((c == 3'h0) ? 3'h4 : c - 3'h1);
				found = !((c == 3'h3 && !manOk) || (c == 3'h4 && !optOk));
			end
		end
		return pkm_feed_t'(c);
	endfunction

endpackage

// ===== core/pkm_panel_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module pkm_panel_ctrl #(
	parameter int unsigned DEBOUNCE_CYC   = pkm_pkg::DEBOUNCE_CYC,
	parameter int unsigned RESET_HOLD_CYC = pkm_pkg::RESET_HOLD_CYC,
	parameter int unsigned TEST_HOLD_CYC  = pkm_pkg::TEST_HOLD_CYC,
	parameter int unsigned MULTI_WIN_CYC  = pkm_pkg::MULTI_WIN_CYC
) (
	input  wire logic                     clk_sys,
	input  wire logic                     srst,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic [31:0]                   prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic [pkm_pkg::NUM_KEYS-1:0] keyRaw,
	input  wire logic                     dataLed,
	input  wire logic                     readyLed,
	input  wire logic                     facedownSel,
	input  wire logic                     faceupSel,
	input  wire logic                     envFeederPresent,
	input  wire logic                     sizeMismatch,
	input  wire logic                     upperHasPaper,
	input  wire logic                     manualPaper,
	output logic                          beep,
	output logic                          formFeedGo,
	output logic                          alarmClear,
	output logic                          testPageA,
	output logic                          fontList,
	output logic                          testBRun,
	output logic                          pageMemClear,
	output logic                          loadStored,
	output logic                          ctrlRepMode,
	output logic                          duplexOn,
	output pkm_pkg::pkm_feed_t            feedSrc,
	output logic [3:0]                    feedLed,
	output logic                          cassetteUpper,
	output logic                          sizeError,
	output logic                          feedClutch,
	output logic [8:0]                    hBeamStart,
	output logic [8:0]                    vClutchDelay,
	output pkm_pkg::pkm_level_t           dispLevel,
	output logic [4:0]                    dispSelect,
	output logic                          dispIsCurrent,
	output pkm_pkg::pkm_msg_t             dispMsg
);
	import pkm_pkg::*;

	localparam int DEB_W = $clog2(DEBOUNCE_CYC + 1);

	// Elaboration check on counts
	if (DEBOUNCE_CYC < 1 || RESET_HOLD_CYC < 1 || MULTI_WIN_CYC < 1 ||
		TEST_HOLD_CYC <= MULTI_WIN_CYC) begin : g_chk
		$error("pkm_panel_ctrl: count parameters out of range");
	end

	// ************************************************************
	// Key debounce
	// ************************************************************
	logic [NUM_KEYS-1:0] keyDown;
	logic [NUM_KEYS-1:0] keyPress;

	for (genvar k = 0; k < NUM_KEYS; k++) begin : g_deb
		logic [DEB_W-1:0] cnt_q;
		logic             stable_q;
		// Level must hold a full interval before it is believed
		always_ff @(posedge clk_sys) begin
			if (srst) begin
				cnt_q    <= '0;
				stable_q <= 1'b0;
			end else if (keyRaw[k] == stable_q) begin
				cnt_q <= '0;
			end else if (cnt_q == DEB_W'(DEBOUNCE_CYC - 1)) begin
				cnt_q    <= '0;
				stable_q <= keyRaw[k];
			end else begin
				cnt_q <= cnt_q + DEB_W'(1);
			end
		end
		assign keyDown[k]  = stable_q;
		assign keyPress[k] = keyRaw[k] && !stable_q && cnt_q == DEB_W'(DEBOUNCE_CYC - 1);
	end

	// ************************************************************
	// Key routing
	// ************************************************************
	logic       online_q;
	logic       simplexTest_q;
	pkm_level_t level_q;
	logic       inMenu, panelOk;
	logic       kEnter, kUp, kDown, kLeft, kRight;
	logic       manOk, optOk;

	assign inMenu  = level_q != LV_OFFLINE;
	assign panelOk = !online_q && !inMenu;
	// Dual-labelled keys become navigation keys inside the menu
	assign kEnter = keyPress[KEY_FORMFEED] && inMenu;
	assign kUp    = keyPress[KEY_ALARM] && inMenu;
	assign kDown  = keyPress[KEY_TEST] && inMenu;
	assign kLeft  = keyPress[KEY_DUPLEX] && inMenu;
	assign kRight = keyPress[KEY_FEEDER] && inMenu;
	assign manOk  = simplexTest_q;
	assign optOk  = envFeederPresent && faceupSel && !duplexOn;

	// ************************************************************
	// Menu navigation
	// ************************************************************
	logic setupIdx_q;
	logic featIdx_q;

	// Online forces the panel back to the ready level
	always_ff @(posedge clk_sys) begin
		if (srst || online_q) begin
			level_q    <= LV_OFFLINE;
			setupIdx_q <= 1'b0;
			featIdx_q  <= 1'b0;
		end else begin
			case (level_q)
				LV_OFFLINE: begin
					if (keyPress[KEY_MENU]) begin
						level_q <= LV_SETUP;
					end
				end
				LV_SETUP: begin
					if (kDown) begin
						level_q   <= LV_FEATURE;
						featIdx_q <= 1'b0;
					end else if (kUp) begin
						level_q <= LV_OFFLINE;
					end else if (kLeft || kRight) begin
						setupIdx_q <= !setupIdx_q;
					end
				end
				LV_FEATURE: begin
					if (kDown) begin
						level_q <= LV_VALUE;
					end else if (kUp) begin
						level_q <= LV_SETUP;
					end else if ((kLeft || kRight) && setupIdx_q) begin
						featIdx_q <= !featIdx_q;
					end
				end
				LV_VALUE: begin
					// Down is ignored here
					if (kUp) begin
						level_q <= LV_FEATURE;
					end
				end
				default: level_q <= LV_OFFLINE;
			endcase
		end
	end

	// ************************************************************
	// Pending values and active settings
	// ************************************************************
	pkm_feed_t  feed_q, pendFeed_q;
	logic [4:0] hShift_q, vShift_q, pendH_q, pendV_q;
	logic       atValue, offX, offY;

	assign atValue = level_q == LV_VALUE;
	assign offX    = setupIdx_q && !featIdx_q;
	assign offY    = setupIdx_q && featIdx_q;

	// Pending copy is loaded on the way into the value level
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pendFeed_q <= FD_AUTO;
			pendH_q    <= OFFSET_RST;
			pendV_q    <= OFFSET_RST;
		end else if ((level_q == LV_FEATURE && kDown) || keyPress[KEY_RESET]) begin
			pendFeed_q <= feed_q;
			pendH_q    <= hShift_q;
			pendV_q    <= vShift_q;
		end else if (atValue && (kLeft || kRight)) begin
			if (!setupIdx_q) begin
				pendFeed_q <= pkmNextFeed(pendFeed_q, kRight, manOk, optOk);
			end else if (kRight) begin
				// Saturate rather than wrap so the image never jumps
				if (offX && pendH_q != OFFSET_MAX) pendH_q <= pendH_q + 5'h01;
				if (offY && pendV_q != OFFSET_MAX) pendV_q <= pendV_q + 5'h01;
			end else begin
				if (offX && pendH_q != OFFSET_RST) pendH_q <= pendH_q - 5'h01;
				if (offY && pendV_q != OFFSET_RST) pendV_q <= pendV_q - 5'h01;
			end
		end
	end

	// Active settings: enter commits, feeder key steps directly
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			feed_q   <= FD_AUTO;
			hShift_q <= OFFSET_RST;
			vShift_q <= OFFSET_RST;
		end else if (atValue && kEnter) begin
			if (!setupIdx_q) feed_q <= pendFeed_q;
			if (offX) hShift_q <= pendH_q;
			if (offY) vShift_q <= pendV_q;
		end else if (panelOk && keyPress[KEY_FEEDER]) begin
			feed_q <= pkmNextFeed(feed_q, 1'b1, manOk, optOk);
		end
	end
	assign feedSrc = feed_q;

	// Image shift in dots; beam start for X, clutch timing for Y
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			hBeamStart   <= '0;
			vClutchDelay <= '0;
		end else begin
			hBeamStart   <= 9'(hShift_q) * DOTS_PER_STEP;
			vClutchDelay <= 9'(vShift_q) * DOTS_PER_STEP;
		end
	end

	// ************************************************************
	// Feed path
	// ************************************************************
	// Auto follows the cassette with paper; size check only in auto
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cassetteUpper <= 1'b0;
			sizeError     <= 1'b0;
			feedClutch    <= 1'b0;
			feedLed       <= 4'h0;
		end else begin
			cassetteUpper <= (feed_q == FD_AUTO) ? upperHasPaper : (feed_q == FD_UPPER);
			sizeError     <= (feed_q == FD_AUTO) && sizeMismatch;
			feedClutch    <= (feed_q == FD_MANUAL) && manualPaper;
			feedLed[0]    <= feed_q == FD_LOWER || (feed_q == FD_AUTO && !upperHasPaper);
			feedLed[1]    <= feed_q == FD_UPPER || (feed_q == FD_AUTO && upperHasPaper);
			feedLed[2]    <= feed_q == FD_MANUAL;
			feedLed[3]    <= feed_q == FD_OPTION;
		end
	end

	// ************************************************************
	// Offline keys
	// ************************************************************
	logic anyPress;
	assign anyPress = |(keyPress & ~(NUM_KEYS'(1) << KEY_ALARM));

	// One-cycle command pulses
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			beep         <= 1'b0;
			formFeedGo   <= 1'b0;
			alarmClear   <= 1'b0;
			pageMemClear <= 1'b0;
			loadStored   <= 1'b0;
		end else begin
			beep         <= online_q && anyPress;
			formFeedGo   <= panelOk && keyPress[KEY_FORMFEED] && dataLed && readyLed;
			alarmClear   <= !inMenu && keyPress[KEY_ALARM];
			pageMemClear <= panelOk && keyPress[KEY_RESET];
			loadStored   <= panelOk && keyPress[KEY_RESET];
		end
	end

	// Duplex cannot be written over the bus, only toggled by this key
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			duplexOn <= 1'b0;
		end else if (panelOk && keyPress[KEY_DUPLEX] && facedownSel) begin
			duplexOn <= !duplexOn;
		end
	end

	// Reset key hold timer, separate from all other keys
	logic [31:0] rstHold_q;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rstHold_q   <= '0;
			ctrlRepMode <= 1'b0;
		end else if (!keyDown[KEY_RESET] || !panelOk) begin
			rstHold_q <= '0;
		end else if (rstHold_q == RESET_HOLD_CYC) begin
			ctrlRepMode <= 1'b1;
		end else begin
			rstHold_q <= rstHold_q + 32'h1;
		end
	end

	// ************************************************************
	// Test key decoder
	// ************************************************************
	pkm_test_t   tst_q;
	logic [1:0]  tstCnt_q;
	logic [31:0] tstTmr_q;
	logic        fromRun_q;
	logic        tPress, testStopEvt;

	// A press on the window's last cycle keeps counting, so it is no stop
	assign tPress      = panelOk && keyPress[KEY_TEST];
	assign testStopEvt = tst_q == TS_COUNT && !keyDown[KEY_TEST] && !tPress &&
		tstTmr_q >= MULTI_WIN_CYC - 1 && (fromRun_q ? tstCnt_q >= 2'h2 : tstCnt_q == 2'h3);

	// Presses are counted inside a window; a long first hold means run
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tst_q     <= TS_IDLE;
			tstCnt_q  <= 2'h0;
			tstTmr_q  <= '0;
			fromRun_q <= 1'b0;
			testPageA <= 1'b0;
			fontList  <= 1'b0;
		end else begin
			testPageA <= 1'b0;
			fontList  <= 1'b0;
			case (tst_q)
				TS_IDLE, TS_RUN: begin
					if (tPress) begin
						fromRun_q <= tst_q == TS_RUN;
						tst_q     <= TS_COUNT;
						tstCnt_q  <= 2'h1;
						tstTmr_q  <= '0;
					end
				end
				TS_COUNT: begin
					tstTmr_q <= tstTmr_q + 32'h1;
					if (tPress) begin
						tstTmr_q <= '0;
						if (tstCnt_q != 2'h3) tstCnt_q <= tstCnt_q + 2'h1;
					end else if (keyDown[KEY_TEST] && !fromRun_q && tstCnt_q == 2'h1 &&
						tstTmr_q >= TEST_HOLD_CYC - 1) begin
						tst_q <= TS_RUN;
					end else if (!keyDown[KEY_TEST] && tstTmr_q >= MULTI_WIN_CYC - 1) begin
						tst_q     <= TS_IDLE;
						testPageA <= !fromRun_q && tstCnt_q == 2'h1;
						fontList  <= !fromRun_q && tstCnt_q == 2'h2;
					end
				end
				default: tst_q <= TS_IDLE;
			endcase
		end
	end
	assign testBRun = tst_q == TS_RUN;

	// ************************************************************
	// Display
	// ************************************************************
	logic feedChanged;
	assign feedChanged = panelOk && keyPress[KEY_FEEDER];

	// Text always sits left-justified with the cursor in column zero
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			dispLevel     <= LV_OFFLINE;
			dispSelect    <= '0;
			dispIsCurrent <= 1'b0;
		end else begin
			dispLevel <= level_q;
			case (level_q)
				LV_SETUP:   dispSelect <= {4'h0, setupIdx_q};
				LV_FEATURE: dispSelect <= {4'h0, featIdx_q};
				LV_VALUE:   dispSelect <= !setupIdx_q ? {2'h0, pendFeed_q} :
					(featIdx_q ? pendV_q : pendH_q);
				default:    dispSelect <= '0;
			endcase
			dispIsCurrent <= atValue && (!setupIdx_q ? pendFeed_q == feed_q :
				(featIdx_q ? pendV_q == vShift_q : pendH_q == hShift_q));
		end
	end

	// Events win; standing conditions fill in otherwise
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			dispMsg <= MS_READY;
		end else if (!inMenu && keyPress[KEY_ALARM]) begin
			dispMsg <= MS_BLANK;
		end else if (testStopEvt) begin
			dispMsg <= MS_TEST_STOP;
		end else if (feedChanged) begin
			dispMsg <= MS_FEEDER;
		end else if (sizeError) begin
			dispMsg <= MS_SIZE_ERR;
		end else if (feed_q == FD_MANUAL && !manualPaper) begin
			dispMsg <= MS_LOAD_MANUAL;
		end else if (dispMsg == MS_SIZE_ERR || dispMsg == MS_LOAD_MANUAL) begin
			dispMsg <= MS_READY;
		end
	end

	// ************************************************************
	// APB slave
	// ************************************************************
	logic setupPh, wrAcc, mapped;
	assign setupPh = psel && !penable;
	assign wrAcc   = psel && penable && pwrite;
	assign mapped  = paddr == REG_CTRL || paddr == REG_STATUS || paddr == REG_OFFSET;
	assign pready  = 1'b1;

	// Read data captured in setup so it comes from a flop
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (setupPh) begin
			pslverr <= !mapped;
			case (paddr)
				REG_CTRL:   prdata <= {30'h0, simplexTest_q, online_q};
				REG_STATUS: prdata <= {23'h0, sizeError, ctrlRepMode, testBRun, duplexOn,
					feed_q, level_q};
				REG_OFFSET: prdata <= {19'h0, vShift_q, 3'h0, hShift_q};
				default:    prdata <= '0;
			endcase
		end
	end

	// Only mode bits are writable; duplex is deliberately absent
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			{simplexTest_q, online_q} <= CTRL_RST;
		end else if (wrAcc && paddr == REG_CTRL) begin
			{simplexTest_q, online_q} <= pwdata[1:0];
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	sequence s_ffOk;
		panelOk && keyPress[KEY_FORMFEED] && dataLed && readyLed;
	endsequence
	sequence s_testHeld;
		tst_q == TS_COUNT && keyDown[KEY_TEST] && !fromRun_q && tstCnt_q == 2'h1 &&
			!tPress && tstTmr_q >= TEST_HOLD_CYC - 1;
	endsequence

	a_formfeed_gate: assert property (@(posedge clk_sys) disable iff (srst)
		formFeedGo |-> $past(panelOk && dataLed && readyLed))
		else $error("form feed issued outside its condition");
	a_formfeed_go: assert property (@(posedge clk_sys) disable iff (srst)
		s_ffOk |=> formFeedGo ##1 !formFeedGo)
		else $error("form feed not issued as one pulse");
	a_alarm_clear: assert property (@(posedge clk_sys) disable iff (srst)
		(!inMenu && keyPress[KEY_ALARM]) |=> alarmClear && dispMsg == MS_BLANK)
		else $error("alarm clear missing");
	a_duplex_gate: assert property (@(posedge clk_sys) disable iff (srst)
		$changed(duplexOn) |-> $past(facedownSel && keyPress[KEY_DUPLEX] && panelOk))
		else $error("duplex changed without facedown key");
	a_online_beep: assert property (@(posedge clk_sys) disable iff (srst)
		(online_q && anyPress) |=> beep && $stable(duplexOn) && $stable(feed_q))
		else $error("disabled key not refused");
	a_manual_skip: assert property (@(posedge clk_sys) disable iff (srst)
		($changed(feed_q) && feed_q == FD_MANUAL) |-> $past(simplexTest_q))
		else $error("manual feed offered outside test mode");
	a_offset_limit: assert property (@(posedge clk_sys) disable iff (srst)
		hShift_q <= OFFSET_MAX && vShift_q <= OFFSET_MAX &&
			pendH_q <= OFFSET_MAX && pendV_q <= OFFSET_MAX)
		else $error("offset out of range");
	a_dots_track: assert property (@(posedge clk_sys) disable iff (srst)
		$changed(hShift_q) |=> hBeamStart == 9'(($past(hShift_q)) * 15))
		else $error("beam start not 15 dots per step");
	a_down_stops: assert property (@(posedge clk_sys) disable iff (srst || online_q)
		(atValue && kDown && !kUp) |=> atValue [*2])
		else $error("down moved past value level");
	a_up_steps: assert property (@(posedge clk_sys) disable iff (srst || online_q)
		(atValue && kUp) |=> level_q == LV_FEATURE)
		else $error("up did not return to feature level");
	a_test_run: assert property (@(posedge clk_sys) disable iff (srst)
		s_testHeld |=> testBRun throughout (!tPress) [*1])
		else $error("held test key did not start run");
	a_test_stop: assert property (@(posedge clk_sys) disable iff (srst)
		testStopEvt |=> !testBRun && !testPageA && (dispMsg == MS_TEST_STOP || $past(keyPress[KEY_ALARM])))
		else $error("test stop not shown");

endmodule // pkm_panel_ctrl
`default_nettype wire

// ===== sim/pkm_operator.sv
`timescale 1ns/100ps
`default_nettype none
// Operator at the keypad: holds one key, lets go, then pauses
module pkm_operator (
	input  wire logic                         clk_sys,
	output var  logic [pkm_pkg::NUM_KEYS-1:0] keyRaw
);
	import pkm_pkg::*;
	// All keys released at power-up
	initial keyRaw = 7'h00;
	// Hold and gap both outlast the debounce span, so each press settles
	task automatic press(input int k, input int hold);
		@(posedge clk_sys) keyRaw[k] <= 1'b1;
		repeat (hold) @(posedge clk_sys);
		keyRaw[k] <= 1'b0;
		repeat (10) @(posedge clk_sys); // Release must settle too
	endtask
endmodule // pkm_operator
`default_nettype wire

// ===== sim/panel_key_menu_controller_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
	$display("[ERR] %0t %h %h", $time, a, b); end end
module panel_key_menu_controller_tb;
	import pkm_pkg::*;
	logic        clk_sys, srst, psel, penable, pwrite, pready, pslverr, err;
	logic        dataLed, readyLed, facedownSel, faceupSel, envFeederPresent;
	logic        sizeMismatch, upperHasPaper, manualPaper, beep, formFeedGo;
	logic        alarmClear, testPageA, loadStored, ctrlRepMode, duplexOn;
	logic        sizeError, dispIsCurrent, fontList, testBRun, pageMemClear;
	logic        cassetteUpper, feedClutch;
	logic [3:0]  feedLed;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [6:0]  keyRaw;
	logic [8:0]  hBeamStart, vClutchDelay;
	logic [4:0]  dispSelect;
	pkm_feed_t   feedSrc;
	pkm_level_t  dispLevel;
	pkm_msg_t    dispMsg;
	int          errors, checks_done, cyc, pc[7];
	int          seed = 32'h518b8e49;
	wire logic [6:0] pul = {pageMemClear, fontList, beep, formFeedGo, alarmClear, testPageA,
		loadStored};
	pkm_panel_ctrl #(.DEBOUNCE_CYC(4), .RESET_HOLD_CYC(50), .TEST_HOLD_CYC(40),
		.MULTI_WIN_CYC(20)) pkm_panel_ctrl_inst (.clk_sys, .srst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .keyRaw, .dataLed,
		.readyLed, .facedownSel, .faceupSel, .envFeederPresent, .sizeMismatch,
		.upperHasPaper, .manualPaper, .beep, .formFeedGo, .alarmClear, .testPageA,
		.fontList, .testBRun, .pageMemClear, .loadStored, .ctrlRepMode,
		.duplexOn, .feedSrc, .feedLed, .cassetteUpper, .sizeError, .feedClutch,
		.hBeamStart, .vClutchDelay, .dispLevel, .dispSelect, .dispIsCurrent,
		.dispMsg);
	pkm_operator pkm_operator_inst (.clk_sys, .keyRaw);
	// Free-running clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Pulse tallies, and a hang guard well above the expected run
	always @(posedge clk_sys) begin
		for (int i = 0; i < 7; i++) if (pul[i] === 1'b1) pc[i]++;
		cyc++;
		if (cyc == 30000) begin
			errors++;
			summarize();
		end
	end
	// Offset display saturates at ten in half steps
	function automatic logic [4:0] expSel(input int i);
		return (i > 20) ? 5'h14 : 5'(i);
	endfunction
	function automatic logic [8:0] dots(input int h);
		return 9'(h * DOTS_PER_STEP);
	endfunction
	// Upper flag over the lamps for feed code f; auto lights the loaded cassette
	function automatic logic [4:0] expFeed(input int f);
		logic [3:0] l;
		l = (f == 0) ? {2'b00, upperHasPaper, !upperHasPaper} : 4'(1 << (f - 1));
		return {l[1], l};
	endfunction
	// One APB cycle; held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk_sys) penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	// Random hold keeps press lengths varied but repeatable
	task automatic key(input int k);
		pkm_operator_inst.press(k, 6 + $unsigned($random(seed)) % 4);
	endtask
	task automatic summarize();
		if (errors == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
		{dataLed, readyLed, facedownSel, faceupSel, envFeederPresent} = 5'h00;
		{sizeMismatch, manualPaper} = 2'h0;
		upperHasPaper = 1'($random(seed));
		repeat (6) @(posedge clk_sys);
		srst <= 1'b0;
		`CHK(feedSrc, FD_AUTO)
		apb(1'b1, REG_CTRL, 32'h1);
		apb(1'b0, 8'h0c, 32'h0);
		`CHK(err, 1'b1)
		facedownSel <= 1'b1;
		key(KEY_DUPLEX);
		`CHK(pc[4], 1)
		`CHK(duplexOn, 1'b0)
		apb(1'b1, REG_STATUS, 32'h20);
		apb(1'b0, REG_STATUS, 32'h0);
		`CHK(rd[5], 1'b0)
		apb(1'b1, REG_CTRL, 32'h0);
		for (int i = 0; i < 2; i++) begin
			{dataLed, readyLed} <= {1'(i), 1'b1};
			key(KEY_FORMFEED);
			`CHK(pc[3], i)
		end
		for (int i = 0; i < 3; i++) begin
			facedownSel <= (i != 0);
			key(KEY_DUPLEX);
			`CHK(duplexOn, 1'(i == 1))
		end
		// Second pass unlocks manual and option choices
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, REG_CTRL, {30'h0, 1'(m), 1'b0});
			{faceupSel, envFeederPresent} <= {1'(m), 1'(m)};
			for (int i = 0; i < 3 + 2 * m; i++) begin
				manualPaper <= 1'($random(seed));
				key(KEY_FEEDER);
				`CHK(feedSrc, pkm_feed_t'((i + 1) % (3 + 2 * m)))
				`CHK(({cassetteUpper, feedLed}), expFeed((i + 1) % (3 + 2 * m)))
				`CHK(feedClutch, manualPaper && (i + 1) % (3 + 2 * m) == 3)
			end
		end
		sizeMismatch <= 1'b1;
		repeat (3) @(posedge clk_sys);
		`CHK(sizeError, 1'b1)
		key(KEY_ALARM);
		`CHK(pc[2], 1)
		sizeMismatch <= 1'b0;
		// One, two and three presses: page, font list, then the stop message
		for (int n = 1; n < 4; n++) begin
			repeat (n) key(KEY_TEST);
			repeat (30) @(posedge clk_sys);
			`CHK(pc[1], 1)
			`CHK(pc[5], int'(n > 1))
			`CHK(dispMsg, (n == 3) ? MS_TEST_STOP : MS_READY)
		end
		pkm_operator_inst.press(KEY_TEST, 60);
		`CHK(testBRun, 1'b1)
		key(KEY_TEST);
		`CHK(testBRun, 1'b0)
		key(KEY_MENU);
		`CHK(dispLevel, LV_SETUP)
		key(KEY_FEEDER);
		key(KEY_TEST);
		key(KEY_TEST);
		for (int i = 1; i < 23; i++) begin
			key(KEY_FEEDER);
			`CHK(dispSelect, expSel(i))
		end
		key(KEY_FORMFEED);
		`CHK(dispIsCurrent, 1'b1)
		`CHK(hBeamStart, dots(20))
		// Up, scroll to Y, down, one step right, enter
		key(KEY_ALARM);
		key(KEY_FEEDER);
		key(KEY_TEST);
		key(KEY_FEEDER);
		key(KEY_FORMFEED);
		`CHK(vClutchDelay, dots(1))
		`CHK(hBeamStart, dots(20))
		key(KEY_TEST);
		`CHK(dispLevel, LV_VALUE)
		for (int i = 0; i < 4; i++) begin
			key(KEY_ALARM);
			`CHK(dispLevel, pkm_level_t'((i < 3) ? 2 - i : 0))
		end
		apb(1'b0, REG_OFFSET, 32'h0);
		`CHK(rd[4:0], 5'h14)
		`CHK(rd[12:8], 5'h01)
		pkm_operator_inst.press(KEY_RESET, 70);
		`CHK(ctrlRepMode, 1'b1)
		`CHK(pc[0], 1)
		`CHK(pc[6], 1)
		summarize();
	end
endmodule // panel_key_menu_controller_tb
`default_nettype wire
